// [rtl/flash_err_cfg.svh]
// Register offsets, field positions, reset values and command codes
// Behaviour
// - Forced double fault flags every array read
// - Forced single fault flags every array read
// - Force bits clear only by software zero
// - Forced reads leave ECC result untouched
// - Unforced, flags follow real ECC detection
// - Erase error flag requests interrupt when enabled
// - Program error flag requests interrupt when enabled
// - Buffer protection flag requests interrupt when enabled
// - Enable register resets zero, bit five zero
// - Tag counter counts pending words, clear wins
// - Committed when counter zero and not busy
// - Tag counter read only to software
// - Index three to five selects data words
// - Block verify: index nonzero or bad address
// - Load field active at launch gives error
// - Verify errors set status bits zero, one
// - Clearing complete flag launches, sets when done
// - Section verify: index not two, mode
// - Section verify: misaligned or bad address
// - Section verify: range crosses 256K boundary
`ifndef FLASH_ERR_CFG_SVH
`define FLASH_ERR_CFG_SVH
`define IDX_PARAM_INDEX 6'h02
`define IDX_FAULT_FORCE 6'h04
`define IDX_ERR_ENABLES 6'h05
`define IDX_CMD_STATUS 6'h06
`define IDX_ERR_FLAGS 6'h07
`define IDX_PFLASH_PROT 6'h08
`define IDX_EEPROM_PROT 6'h09
`define IDX_PARAM_HIGH 6'h0a
`define IDX_PARAM_LOW 6'h0b
`define IDX_TAG_HIGH 6'h0c
`define IDX_TAG_LOW 6'h0d
`define IDX_ECC_HIGH 6'h0e
`define IDX_ECC_LOW 6'h0f
`define IDX_NV_OPTIONS 6'h10
`define IDX_RSV_A 6'h11
`define IDX_RSV_B 6'h12
`define ENABLES_MASK 8'hdf
`define FLAGS_MASK 8'hdf
`define ENABLES_RESET 8'h00
`define PROT_RESET 8'h00
`define BIT_SINGLE 0
`define BIT_DOUBLE 1
`define BIT_BUF_PROT 4
`define BIT_PROGRAM 6
`define BIT_ERASE 7
`define ST_COMPLETE 7
`define ST_ACCESS 5
`define ST_PROT 4
`define ST_BUSY 3
`define ST_VERR 1
`define ST_VFATAL 0
`define PIDX_ADDR_LO 3'h1
`define PIDX_COUNT 3'h2
`define PIDX_LAST 3'h5
`define CMD_VERIFY_SECTION 8'h03
`define CMD_VERIFY_BLOCK 8'h01
`define PFLASH_HI_MIN 7'h40
`endif

// [rtl/flash_err_pkg.sv]
// Types shared by the flash error control block
package flash_err_pkg;
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_VERIFY = 1'b1
    } verify_state_t;
    typedef logic [15:0] param_word_t;
endpackage : flash_err_pkg

// [rtl/flash_error_control.sv]
// Flash error control, tag counter and erase-verify command checking
`timescale 1ns/10ps
`include "flash_err_cfg.svh"
module flash_error_control
    import flash_err_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Array read and ECC check
    input wire logic array_read,
    input wire logic ecc_single_det,
    input wire logic ecc_double_det,
    input wire logic [15:0] ecc_info,
    // Emulated EEPROM events
    input wire logic erase_fail,
    input wire logic program_fail,
    input wire logic buffer_prot_hit,
    input wire logic tag_increment,
    input wire logic tag_decrement,
    input wire logic tag_clear,
    input wire logic mc_busy,
    // Command context
    input wire logic load_field_active,
    input wire logic section_cmd_allowed,
    input wire logic [7:0] nv_options,
    // Verify engine handshake
    output logic verify_req,
    output logic verify_section,
    output logic [22:0] verify_addr,
    output logic [15:0] verify_count,
    input wire logic verify_done,
    input wire logic verify_err,
    input wire logic verify_fatal,
    // Status outputs
    output logic irq_request,
    output logic all_committed
);
    function automatic logic [7:0] flag_update(input logic [7:0] cur, input logic [7:0] clr,
                                               input logic [7:0] set);
        flag_update = (cur & ~clr) | set;
    endfunction : flag_update

    // Bus decode
    wire logic setup_phase = psel && !penable && !pready;
    wire logic access_done = psel && penable && pready;
    wire logic [5:0] bus_index = paddr[7:2];
    wire logic aligned = (paddr[1:0] == 2'b00);
    wire logic mapped = aligned && (bus_index >= `IDX_PARAM_INDEX) && (bus_index <= `IDX_RSV_B)
                        && (bus_index != 6'h03);
    wire logic wr_en = access_done && pwrite && mapped;
    wire logic wr_index = wr_en && (bus_index == `IDX_PARAM_INDEX);
    wire logic wr_force = wr_en && (bus_index == `IDX_FAULT_FORCE);
    wire logic wr_enables = wr_en && (bus_index == `IDX_ERR_ENABLES);
    wire logic wr_status = wr_en && (bus_index == `IDX_CMD_STATUS);
    wire logic wr_flags = wr_en && (bus_index == `IDX_ERR_FLAGS);
    wire logic wr_pprot = wr_en && (bus_index == `IDX_PFLASH_PROT);
    wire logic wr_eeprom_partition_protection = wr_en && (bus_index == `IDX_EEPROM_PROT);
    wire logic wr_phigh = wr_en && (bus_index == `IDX_PARAM_HIGH);
    wire logic wr_plow = wr_en && (bus_index == `IDX_PARAM_LOW);

    // Registers
    logic [2:0] param_index_reg;
    logic [1:0] force_reg;
    logic [7:0] enables_reg;
    logic [7:0] flags_reg;
    logic [7:0] pprot_reg;
    logic [7:0] eeprom_partition_protection_reg;
    logic complete_reg;
    logic access_err_reg;
    logic prot_viol_reg;
    logic verr_reg;
    logic vfatal_reg;
    logic [15:0] tag_reg;
    logic [15:0] ecc_result_reg;
    param_word_t param_mem [0:5];
    verify_state_t state_reg;
    verify_state_t state_next;

    // Fault injection and detection
    wire logic set_single = array_read && (force_reg[`BIT_SINGLE] || ecc_single_det);
    wire logic set_double = array_read && (force_reg[`BIT_DOUBLE] || ecc_double_det);
    wire logic ecc_capture = array_read && (ecc_single_det || ecc_double_det);
    wire logic [7:0] flag_set = {erase_fail, program_fail, 1'b0, buffer_prot_hit, 2'b00,
                                 set_double, set_single};
    wire logic [7:0] flag_clr = wr_flags ? (pwdata[7:0] & `FLAGS_MASK) : 8'h00;
    wire logic [7:0] flags_next = flag_update(flags_reg, flag_clr, flag_set);
    wire logic irq_next = |(flags_next & enables_reg & `FLAGS_MASK);

    // Tag counter, software cannot write it
    logic [15:0] tag_next;
    always_comb begin
        tag_next = tag_reg;
        if (tag_clear) begin
            tag_next = 16'h0000;
        end else if (tag_increment && !tag_decrement) begin
            tag_next = tag_reg + 16'h0001;
        end else if (tag_decrement && !tag_increment && (tag_reg != 16'h0000)) begin
            tag_next = tag_reg - 16'h0001;
        end
    end
    wire logic busy_now = mc_busy || (state_reg == ST_VERIFY);
    wire logic committed_next = (tag_next == 16'h0000) && !mc_busy
                                && (state_next == ST_IDLE);

    // Command launch checks
    wire logic launch = wr_status && pwdata[`ST_COMPLETE] && complete_reg;
    wire logic [7:0] cmd_code = param_mem[0][15:8];
    wire logic [6:0] addr_hi = param_mem[0][6:0];
    wire logic [15:0] addr_lo = param_mem[1];
    wire logic [15:0] phrase_cnt = param_mem[2];
    wire logic [22:0] start_addr = {addr_hi, addr_lo};
    wire logic [23:0] end_addr = {1'b0, start_addr} + {5'h00, phrase_cnt, 3'b000} - 24'h000001;
    wire logic hi_valid = (addr_hi >= `PFLASH_HI_MIN);
    wire logic is_block = (cmd_code == `CMD_VERIFY_BLOCK);
    wire logic is_section = (cmd_code == `CMD_VERIFY_SECTION);
    wire logic block_bad = (param_index_reg != 3'h0) || !hi_valid;
    wire logic crosses = (phrase_cnt != 16'h0000)
                         && (end_addr[23:18] != {1'b0, start_addr[22:18]});
    wire logic section_bad = (param_index_reg != `PIDX_COUNT) || !section_cmd_allowed
                             || !hi_valid || (start_addr[2:0] != 3'b000) || crosses;
    wire logic launch_bad = load_field_active
                            || (is_block && block_bad) || (is_section && section_bad)
                            || (!is_block && !is_section);
    wire logic launch_ok = launch && !launch_bad;
    wire logic finish = (state_reg == ST_VERIFY) && verify_done;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (launch_ok) begin
                    state_next = ST_VERIFY;
                end
            end
            ST_VERIFY: begin
                if (verify_done) begin
                    state_next = ST_IDLE;
                end
            end
        endcase
    end

    // Read mux
    wire logic [7:0] status_read = {complete_reg, 1'b0, access_err_reg, prot_viol_reg,
                                    busy_now, 1'b0, verr_reg, vfatal_reg};
    wire logic index_ok = (param_index_reg <= `PIDX_LAST);
    wire param_word_t param_sel = index_ok ? param_mem[param_index_reg] : 16'h0000;
    logic [7:0] read_byte;
    always_comb begin
        unique case (bus_index)
            `IDX_PARAM_INDEX: read_byte = {5'h00, param_index_reg};
            `IDX_FAULT_FORCE: read_byte = {6'h00, force_reg};
            `IDX_ERR_ENABLES: read_byte = enables_reg & `ENABLES_MASK;
            `IDX_CMD_STATUS: read_byte = status_read;
            `IDX_ERR_FLAGS: read_byte = flags_reg;
            `IDX_PFLASH_PROT: read_byte = pprot_reg;
            `IDX_EEPROM_PROT: read_byte = eeprom_partition_protection_reg;
            `IDX_PARAM_HIGH: read_byte = param_sel[15:8];
            `IDX_PARAM_LOW: read_byte = param_sel[7:0];
            `IDX_TAG_HIGH: read_byte = tag_reg[15:8];
            `IDX_TAG_LOW: read_byte = tag_reg[7:0];
            `IDX_ECC_HIGH: read_byte = ecc_result_reg[15:8];
            `IDX_ECC_LOW: read_byte = ecc_result_reg[7:0];
            `IDX_NV_OPTIONS: read_byte = nv_options;
            default: read_byte = 8'h00;
        endcase
    end

    // APB answer: one access cycle, no wait states
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup_phase;
            pslverr <= setup_phase && !mapped;
            prdata <= (setup_phase && mapped && !pwrite) ? {24'h000000, read_byte} : 32'h00000000;
        end
    end

    // Software registers
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            param_index_reg <= 3'h0;
            force_reg <= 2'b00;
            enables_reg <= `ENABLES_RESET;
            pprot_reg <= `PROT_RESET;
            eeprom_partition_protection_reg <= `PROT_RESET;
        end else begin
            if (wr_index) param_index_reg <= pwdata[2:0];
            if (wr_force) force_reg <= pwdata[1:0];
            if (wr_enables) enables_reg <= pwdata[7:0] & `ENABLES_MASK;
            if (wr_pprot) pprot_reg <= pwdata[7:0];
            if (wr_eeprom_partition_protection) eeprom_partition_protection_reg <= pwdata[7:0];
        end
    end

    // Parameter words, indexed by the parameter index
    always_ff @(posedge sys_clk) begin
        if ((wr_phigh || wr_plow) && index_ok && complete_reg) begin
            if (wr_phigh) param_mem[param_index_reg][15:8] <= pwdata[7:0];
            if (wr_plow) param_mem[param_index_reg][7:0] <= pwdata[7:0];
        end
    end

    // Flags, tag, ECC result
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            flags_reg <= 8'h00;
            tag_reg <= 16'h0000;
            ecc_result_reg <= 16'h0000;
            irq_request <= 1'b0;
            all_committed <= 1'b1;
        end else begin
            flags_reg <= flags_next;
            tag_reg <= tag_next;
            if (ecc_capture) ecc_result_reg <= ecc_info;
            irq_request <= irq_next;
            all_committed <= committed_next;
        end
    end

    // Command status and verify engine
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            complete_reg <= 1'b1;
            access_err_reg <= 1'b0;
            prot_viol_reg <= 1'b0;
            verr_reg <= 1'b0;
            vfatal_reg <= 1'b0;
            verify_req <= 1'b0;
            verify_section <= 1'b0;
            verify_addr <= 23'h000000;
            verify_count <= 16'h0000;
        end else begin
            state_reg <= state_next;
            if (launch) begin
                complete_reg <= launch_bad;
                verr_reg <= 1'b0;
                vfatal_reg <= 1'b0;
            end else if (finish) begin
                complete_reg <= 1'b1;
                verr_reg <= verify_err;
                vfatal_reg <= verify_fatal;
            end
            if (launch && launch_bad) begin
                access_err_reg <= 1'b1;
            end else if (wr_status && pwdata[`ST_ACCESS]) begin
                access_err_reg <= 1'b0;
            end
            if (wr_status && pwdata[`ST_PROT]) prot_viol_reg <= 1'b0;
            if (launch_ok) begin
                verify_req <= 1'b1;
                verify_section <= is_section;
                verify_addr <= is_section ? start_addr : {addr_hi, 16'h0000};
                verify_count <= is_section ? phrase_cnt : 16'h0000;
            end else if (finish) begin
                verify_req <= 1'b0;
            end
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence s_bad_launch;
        launch && launch_bad;
    endsequence
    sequence s_error_shown;
        access_err_reg && complete_reg && (state_reg == ST_IDLE);
    endsequence
    sequence s_good_launch;
        launch_ok;
    endsequence
    sequence s_verify_running;
        verify_req && !complete_reg && (state_reg == ST_VERIFY);
    endsequence

    AST_FORCE_DOUBLE: assert property (array_read && force_reg[`BIT_DOUBLE]
        |=> flags_reg[`BIT_DOUBLE])
        else $error("forced double fault did not set flag");
    AST_FORCE_SINGLE: assert property (array_read && force_reg[`BIT_SINGLE]
        |=> flags_reg[`BIT_SINGLE])
        else $error("forced single fault did not set flag");
    AST_FORCE_HOLD: assert property (!wr_force |=> force_reg == $past(force_reg))
        else $error("force bits changed without a write");

    AST_ECC_KEEP: assert property (!(array_read && (ecc_single_det || ecc_double_det))
        |=> $stable(ecc_result_reg))
        else $error("ecc result changed without a real fault");
    AST_ECC_CAPTURE: assert property (array_read && ecc_single_det
        |=> ecc_result_reg == $past(ecc_info))
        else $error("ecc result not captured");
    AST_SINGLE_CAUSE: assert property ($rose(flags_reg[`BIT_SINGLE])
        |-> $past(array_read && (force_reg[0] || ecc_single_det)))
        else $error("single fault flag set without cause");
    AST_DOUBLE_CAUSE: assert property ($rose(flags_reg[`BIT_DOUBLE])
        |-> $past(array_read && (force_reg[`BIT_DOUBLE] || ecc_double_det)))
        else $error("double fault flag set without cause");

    AST_ERASE_IRQ: assert property (flags_reg[`BIT_ERASE] && enables_reg[`BIT_ERASE]
        |-> ##[0:1] irq_request)
        else $error("erase error interrupt missing");
    AST_PROGRAM_IRQ: assert property (flags_reg[`BIT_PROGRAM] && enables_reg[`BIT_PROGRAM]
        |-> ##[0:1] irq_request)
        else $error("program error interrupt missing");
    AST_PROT_IRQ: assert property (buffer_prot_hit && enables_reg[`BIT_BUF_PROT]
        |=> irq_request && flags_reg[`BIT_BUF_PROT])
        else $error("protection interrupt missing");
    AST_BIT5_ZERO: assert property (enables_reg[5] == 1'b0)
        else $error("enable bit five set");

    AST_TAG_DEC: assert property (tag_decrement && !tag_increment && !tag_clear
        && tag_reg != 16'h0000 |=> tag_reg == $past(tag_reg) - 16'h0001)
        else $error("tag counter did not decrement");
    AST_TAG_INC: assert property (tag_increment && !tag_decrement && !tag_clear
        |=> tag_reg == $past(tag_reg) + 16'h0001)
        else $error("tag counter did not increment");
    AST_COMMITTED: assert property (all_committed == ((tag_reg == 16'h0000)
        && !$past(mc_busy) && (state_reg == ST_IDLE)))
        else $error("committed indication wrong");
    AST_TAG_RO: assert property (!tag_increment && !tag_decrement && !tag_clear
        |=> $stable(tag_reg))
        else $error("tag counter changed by software");
    AST_TAG_CLEAR: assert property (tag_clear
        |=> tag_reg == 16'h0000)
        else $error("tag counter not cleared");

    AST_BLOCK_INDEX: assert property (launch && is_block && param_index_reg != 3'h0
        |=> access_err_reg && !verify_req)
        else $error("block verify index error missed");
    AST_BLOCK_ADDR: assert property (launch && is_block && !hi_valid
        |=> access_err_reg && !verify_req)
        else $error("block verify address error missed");
    AST_LOAD_ACTIVE: assert property (launch && load_field_active |=> access_err_reg)
        else $error("load field error missed");

    AST_VERIFY_RESULT: assert property (finish |=> verr_reg == $past(verify_err)
        && vfatal_reg == $past(verify_fatal) && $stable(prot_viol_reg))
        else $error("verify result bits wrong");
    AST_LAUNCH_DONE: assert property (launch_ok |=> !complete_reg && verify_req)
        else $error("launch did not start verify");
    AST_VERIFY_HOLD: assert property (s_good_launch |=> s_verify_running)
        else $error("verify did not start");
    AST_VERIFY_END: assert property (finish
        |=> complete_reg && !verify_req)
        else $error("verify did not finish");

    AST_SECTION_BAD: assert property (s_bad_launch |=> s_error_shown)
        else $error("bad section launch not refused");
    AST_SECTION_INDEX: assert property (launch && is_section
        && param_index_reg != `PIDX_COUNT |=> access_err_reg && !verify_req)
        else $error("section index error missed");
    AST_SECTION_ALIGN: assert property (launch && is_section
        && start_addr[2:0] != 3'b000 |=> access_err_reg && !verify_req)
        else $error("misaligned section not refused");
    AST_SECTION_CROSS: assert property (launch && is_section && crosses
        |=> access_err_reg && !verify_req)
        else $error("boundary crossing not refused");

    AST_FLAG_STICKY: assert property (flags_reg[`BIT_ERASE] && !wr_flags
        |=> flags_reg[`BIT_ERASE])
        else $error("error flag cleared itself");
endmodule : flash_error_control

// [tb/test_flash_error_control.sv]
// Self-checking bench for the flash error control block
`timescale 1ns/10ps
`include "flash_err_cfg.svh"
module test_flash_error_control;
    import flash_err_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, verify_req, verify_section, irq_request, all_committed;
    wire logic [22:0] verify_addr;
    wire logic [15:0] verify_count;
    logic array_read = 1'b0, ecc_single_det = 1'b0, ecc_double_det = 1'b0;
    logic [15:0] ecc_info = 16'h0;
    logic erase_fail = 1'b0, program_fail = 1'b0, buffer_prot_hit = 1'b0;
    logic tag_increment = 1'b0, tag_decrement = 1'b0, tag_clear = 1'b0, mc_busy = 1'b0;
    logic load_field_active = 1'b0, section_cmd_allowed = 1'b1;
    logic [7:0] nv_options = 8'h5a;
    logic verify_done = 1'b0, verify_err = 1'b0, verify_fatal = 1'b0;
    int err_count = 0;
    int num_checks = 0;
    int ebit [3] = '{7, 6, 4};

    flash_error_control dut_u (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .array_read(array_read), .ecc_single_det(ecc_single_det),
        .ecc_double_det(ecc_double_det), .ecc_info(ecc_info), .erase_fail(erase_fail),
        .program_fail(program_fail), .buffer_prot_hit(buffer_prot_hit),
        .tag_increment(tag_increment), .tag_decrement(tag_decrement), .tag_clear(tag_clear),
        .mc_busy(mc_busy), .load_field_active(load_field_active),
        .section_cmd_allowed(section_cmd_allowed), .nv_options(nv_options),
        .verify_req(verify_req), .verify_section(verify_section), .verify_addr(verify_addr),
        .verify_count(verify_count), .verify_done(verify_done), .verify_err(verify_err),
        .verify_fatal(verify_fatal), .irq_request(irq_request), .all_committed(all_committed));

    always #10 sys_clk = ~sys_clk;

    task complete_run();
        $display("checks=%0d mismatches=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer, held until pready is sampled high
    task xfer(input logic [5:0] idx, input logic wr_en, input logic [7:0] d,
              output logic [31:0] rd, output logic err);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr_en;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task wr(input logic [5:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        xfer(idx, 1'b1, d, r, e);
    endtask : wr

    task rdc(input logic [5:0] idx, input logic [7:0] exp, input logic se = 1'b0);
        logic [31:0] r;
        logic e;
        xfer(idx, 1'b0, 8'h00, r, e);
        chk(r, {24'h0, exp});
        chk({31'h0, e}, {31'h0, se});
    endtask : rdc

    // Pulse one event input for a cycle, then let its effects land
    task ev(input int k);
        @(posedge sys_clk);
        case (k)
            0: array_read <= 1'b1;
            4: buffer_prot_hit <= 1'b1;
            6: program_fail <= 1'b1;
            7: erase_fail <= 1'b1;
            8: tag_increment <= 1'b1;
            9: tag_decrement <= 1'b1;
            10: tag_clear <= 1'b1;
            default: verify_done <= 1'b1;
        endcase
        @(posedge sys_clk);
        {array_read, buffer_prot_hit, program_fail, erase_fail} <= 4'h0;
        {tag_increment, tag_decrement, tag_clear, verify_done} <= 4'h0;
        repeat (2) @(posedge sys_clk);
    endtask : ev

    task param(input logic [2:0] ix, input logic [15:0] w);
        wr(`IDX_PARAM_INDEX, {5'h0, ix});
        wr(`IDX_PARAM_HIGH, w[15:8]);
        wr(`IDX_PARAM_LOW, w[7:0]);
    endtask : param

    // Load, launch and either expect refusal or run the verify to its end
    task cmd(input logic [7:0] code, input logic [6:0] hi, input logic [15:0] lo,
             input logic [15:0] cnt, input logic [2:0] fix, input logic bad);
        logic sec;
        sec = (code == `CMD_VERIFY_SECTION);
        param(3'h0, {code, 1'b0, hi});
        param(3'h1, lo);
        param(3'h2, cnt);
        wr(`IDX_PARAM_INDEX, {5'h0, fix});
        wr(`IDX_CMD_STATUS, 8'h80);
        repeat (2) @(posedge sys_clk);
        if (bad) begin
            chk({31'h0, verify_req}, 32'h0);
            rdc(`IDX_CMD_STATUS, 8'ha0);
            wr(`IDX_CMD_STATUS, 8'h20);
            rdc(`IDX_CMD_STATUS, 8'h80);
        end else begin
            chk({31'h0, verify_req}, 32'h1);
            chk({31'h0, verify_section}, {31'h0, sec});
            chk({9'h0, verify_addr}, {9'h0, sec ? {hi, lo} : {hi, 16'h0}});
            chk({16'h0, verify_count}, {16'h0, sec ? cnt : 16'h0});
            rdc(`IDX_CMD_STATUS, 8'h08);
            verify_err <= 1'b1;
            verify_fatal <= ~sec;
            ev(11);
            chk({31'h0, verify_req}, 32'h0);
            rdc(`IDX_CMD_STATUS, {6'h20, 1'b1, ~sec});
            rdc(`IDX_ERR_FLAGS, 8'h00);
        end
    endtask : cmd

    initial begin
        #200000;
        err_count++;
        complete_run();
    end

    initial begin
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        chk({31'h0, all_committed}, 32'h1);
        rdc(`IDX_ERR_ENABLES, 8'h00);
        rdc(`IDX_CMD_STATUS, 8'h80);
        rdc(6'h00, 8'h00, 1'b1);
        rdc(`IDX_NV_OPTIONS, 8'h5a);
        rdc(`IDX_RSV_A, 8'h00);
        wr(`IDX_ERR_ENABLES, 8'hff);
        rdc(`IDX_ERR_ENABLES, 8'hdf);
        wr(`IDX_ERR_ENABLES, 8'h00);
        $display("test registers done");
        repeat (3) ev(8);
        rdc(`IDX_TAG_LOW, 8'h03);
        chk({31'h0, all_committed}, 32'h0);
        wr(`IDX_TAG_LOW, 8'h00);
        rdc(`IDX_TAG_LOW, 8'h03);
        ev(9);
        rdc(`IDX_TAG_LOW, 8'h02);
        ev(10);
        rdc(`IDX_TAG_LOW, 8'h00);
        chk({31'h0, all_committed}, 32'h1);
        mc_busy <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk({31'h0, all_committed}, 32'h0);
        mc_busy <= 1'b0;
        $display("test tag counter done");
        ecc_info <= 16'h1234;
        ev(0);
        rdc(`IDX_ERR_FLAGS, 8'h00);
        ecc_single_det <= 1'b1;
        ev(0);
        ecc_single_det <= 1'b0;
        rdc(`IDX_ERR_FLAGS, 8'h01);
        rdc(`IDX_ECC_HIGH, 8'h12);
        wr(`IDX_ERR_FLAGS, 8'hff);
        ecc_double_det <= 1'b1;
        ev(0);
        ecc_double_det <= 1'b0;
        rdc(`IDX_ERR_FLAGS, 8'h02);
        wr(`IDX_ERR_FLAGS, 8'hff);
        wr(`IDX_ERR_ENABLES, 8'h03);
        wr(`IDX_FAULT_FORCE, 8'h03);
        ecc_info <= 16'h5678;
        ev(0);
        rdc(`IDX_ERR_FLAGS, 8'h03);
        chk({31'h0, irq_request}, 32'h1);
        rdc(`IDX_ECC_LOW, 8'h34);
        rdc(`IDX_FAULT_FORCE, 8'h03);
        wr(`IDX_ERR_FLAGS, 8'hff);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq_request}, 32'h0);
        ev(0);
        rdc(`IDX_ERR_FLAGS, 8'h03);
        wr(`IDX_FAULT_FORCE, 8'h00);
        wr(`IDX_ERR_FLAGS, 8'hff);
        ev(0);
        rdc(`IDX_ERR_FLAGS, 8'h00);
        wr(`IDX_ERR_ENABLES, 8'h00);
        $display("test ecc faults done");
        for (int i = 0; i < 3; i++) begin
            ev(ebit[i]);
            chk({31'h0, irq_request}, 32'h0);
            wr(`IDX_ERR_ENABLES, 8'h01 << ebit[i]);
            repeat (20) @(posedge sys_clk);
            rdc(`IDX_ERR_FLAGS, 8'h01 << ebit[i]);
            chk({31'h0, irq_request}, 32'h1);
            wr(`IDX_ERR_FLAGS, 8'hff);
            repeat (2) @(posedge sys_clk);
            chk({31'h0, irq_request}, 32'h0);
            ev(ebit[i]);
            chk({31'h0, irq_request}, 32'h1);
            wr(`IDX_ERR_FLAGS, 8'hff);
            wr(`IDX_ERR_ENABLES, 8'h00);
        end
        $display("test error events done");
        param(3'h3, 16'habcd);
        param(3'h5, 16'h1357);
        param(3'h4, 16'hffff);
        wr(`IDX_PARAM_INDEX, 8'h03);
        rdc(`IDX_PARAM_HIGH, 8'hab);
        rdc(`IDX_PARAM_LOW, 8'hcd);
        wr(`IDX_PARAM_INDEX, 8'h05);
        rdc(`IDX_PARAM_LOW, 8'h57);
        wr(`IDX_PARAM_INDEX, 8'h04);
        rdc(`IDX_PARAM_HIGH, 8'hff);
        cmd(`CMD_VERIFY_BLOCK, 7'h41, 16'h0, 16'h0, 3'h0, 1'b0);
        cmd(`CMD_VERIFY_BLOCK, 7'h41, 16'h0, 16'h0, 3'h1, 1'b1);
        cmd(`CMD_VERIFY_BLOCK, 7'h10, 16'h0, 16'h0, 3'h0, 1'b1);
        load_field_active <= 1'b1;
        cmd(`CMD_VERIFY_BLOCK, 7'h41, 16'h0, 16'h0, 3'h0, 1'b1);
        cmd(`CMD_VERIFY_SECTION, 7'h40, 16'h0008, 16'h4, 3'h2, 1'b1);
        load_field_active <= 1'b0;
        cmd(`CMD_VERIFY_SECTION, 7'h40, 16'h0008, 16'h4, 3'h2, 1'b0);
        cmd(`CMD_VERIFY_SECTION, 7'h40, 16'h0008, 16'h4, 3'h1, 1'b1);
        section_cmd_allowed <= 1'b0;
        cmd(`CMD_VERIFY_SECTION, 7'h40, 16'h0008, 16'h4, 3'h2, 1'b1);
        section_cmd_allowed <= 1'b1;
        cmd(`CMD_VERIFY_SECTION, 7'h40, 16'h0004, 16'h4, 3'h2, 1'b1);
        cmd(`CMD_VERIFY_SECTION, 7'h10, 16'h0008, 16'h4, 3'h2, 1'b1);
        cmd(`CMD_VERIFY_SECTION, 7'h43, 16'hfff8, 16'h2, 3'h2, 1'b1);
        cmd(`CMD_VERIFY_SECTION, 7'h43, 16'hfff8, 16'h1, 3'h2, 1'b0);
        $display("test commands done");
        complete_run();
    end
endmodule : test_flash_error_control
